/* tsb_pkg.sv */
// Package with register map, field positions and timing constants of the two-wire control block.
package tsb_pkg;
  localparam logic [7:0] CFG_OFS = 8'h2C;
  localparam logic [7:0] HWGC_OFS = 8'h28;
  localparam logic [7:0] ID0_OFS = 8'h38;
  localparam logic [7:0] ID1_OFS = 8'h3C;
  localparam logic [7:0] ID2_OFS = 8'h40;
  localparam logic [7:0] ID3_OFS = 8'h44;
  localparam logic [7:0] STAT_OFS = 8'h50;
  localparam logic [7:0] MASK_OFS = 8'h54;
  localparam logic [7:0] LIVE_OFS = 8'h58;
  localparam logic [7:0] MADR_OFS = 8'h1C;
  localparam int CFG_SLV_EN = 0;
  localparam int CFG_MST_EN = 1;
  localparam int CFG_RSVD = 2;
  localparam int CFG_GC_EN = 3;
  localparam int CFG_HWGC_EN = 4;
  localparam int CFG_NOBACKOFF = 5;
  localparam int CFG_LOOP = 6;
  localparam int CFG_SCL_EN = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int ST_GC = 0;
  localparam int ST_HWGC = 1;
  localparam int ST_GCRST = 2;
  localparam int ST_GCPROG = 3;
  localparam int ST_ARBLOST = 4;
  localparam int ST_SLVMATCH = 5;
  localparam int ST_WIDTH = 6;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [7:0] GC_PROG_CMD = 8'h04;
  localparam int CLK_MHZ = 250;
  localparam int SCL_HALF_NS = 1200;
  localparam int SCL_HALF_CYC = SCL_HALF_NS * CLK_MHZ / 1000;
  localparam int BACKOFF_US = 20;
  localparam int BACKOFF_CYC = BACKOFF_US * CLK_MHZ;
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic stb;
  } tsb_wbreq_type;
  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } tsb_pins_type;
  typedef enum logic [1:0] {
    EV_NONE,
    EV_START,
    EV_STOP,
    EV_BIT
  } tsb_event_type;
endpackage : tsb_pkg

/* tsb_line_sync.sv */
// Two-stage synchroniser and edge finder for the serial clock and data lines.
module tsb_line_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Raw lines
  input wire tsb_pkg::tsb_pins_type pinsIn,
  // Synchronised lines and events
  output logic sclSync,
  output logic sdaSync,
  output tsb_pkg::tsb_event_type lineEvent
);
  tsb_pkg::tsb_pins_type meta_r;
  tsb_pkg::tsb_pins_type sync_r;
  tsb_pkg::tsb_pins_type last_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '1;
      sync_r <= '1;
      last_r <= '1;
    end else if (clkEn) begin
      meta_r <= pinsIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign sclSync = sync_r.sclIn;
  assign sdaSync = sync_r.sdaIn;

  // Start is data falling with clock high; stop is data rising with clock high.
  always_comb begin
    lineEvent = tsb_pkg::EV_NONE;
    if (sync_r.sclIn && last_r.sclIn && last_r.sdaIn && !sync_r.sdaIn) begin
      lineEvent = tsb_pkg::EV_START;
    end else if (sync_r.sclIn && last_r.sclIn && !last_r.sdaIn && sync_r.sdaIn) begin
      lineEvent = tsb_pkg::EV_STOP;
    end else if (sync_r.sclIn && !last_r.sclIn) begin
      lineEvent = tsb_pkg::EV_BIT;
    end
  end
endmodule : tsb_line_sync

/* tsb_config_ctrl.sv */
// Configuration low byte control of the two-wire controller with Wishbone registers.
// Operation
// - Bit 7 set makes the master drive its serial clock; clear stops it.
// - Bit 6 set loops transmit data back into receive, off the bus.
// - Bit 5 set: after lost arbitration retry at once, no wait.
// - Bit 5 clear: after lost arbitration wait a back-off period before retrying.
// - Bits 4 and 3 set: byte after general call compared to hardware ID.
// - Bit 3 set: slave acknowledges general call address and takes next byte.
// - General call data byte 0x06 resets the serial interface.
// - Any general call sets the general call status flag when enabled.
// - Bit 1 enables the master channel; clear disables it.
// - Bit 0 set: slave matches address against four ID registers.
// - Each of four ID registers holds one slave address to answer.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
module tsb_config_ctrl #(
  parameter int BACKOFF_CYCLES = tsb_pkg::BACKOFF_CYC
) (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Wishbone slave
  input wire logic wbCyc,
  input wire tsb_pkg::tsb_wbreq_type wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Two-wire pins
  input wire tsb_pkg::tsb_pins_type pinsIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  // Master side control
  input wire logic mstStart,
  output logic mstBusy,
  output logic mstArbLost,
  // Interrupt
  output logic irq
);
  typedef enum logic [2:0] {
    SL_IDLE,
    SL_ADDR,
    SL_AACK,
    SL_DATA,
    SL_DACK,
    SL_SKIP
  } tsb_slave_type;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_RUN,
    MS_WAIT
  } tsb_master_type;

  logic [7:0] cfg_r;
  logic [7:0] hwgc_r;
  logic [7:0] mstAdr_r;
  logic [6:0] id_r [4];
  logic [tsb_pkg::ST_WIDTH-1:0] stat_r;
  logic [tsb_pkg::ST_WIDTH-1:0] mask_r;
  logic [tsb_pkg::ST_WIDTH-1:0] evt;
  logic sclSync;
  logic sdaSync;
  logic sclRx;
  logic sdaRx;
  tsb_pkg::tsb_event_type lineEvent;
  tsb_slave_type slv_r;
  tsb_master_type mst_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic gcActive_r;
  logic sdaDrvLow_r;
  logic sclFall;
  logic sclLast_r;
  logic gcReset;
  logic [15:0] sclDiv_r;
  logic sclGen_r;
  logic [31:0] backoff_r;
  logic [7:0] mstShift_r;
  logic [3:0] mstBit_r;
  logic wbHit;
  logic wbRd;
  logic wbWr;
  logic [31:0] rdData;
  logic sclDrv;
  logic sdaDrv;

  function automatic logic idMatch(input logic [6:0] ids [4], input logic [6:0] adr);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      hit = hit | (ids[k] == adr);
    end
    return hit;
  endfunction : idMatch

  tsb_line_sync uSync (
    .clock(clock),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .pinsIn(pinsIn),
    .sclSync(sclSync),
    .sdaSync(sdaSync),
    .lineEvent(lineEvent)
  );

  // Wishbone classic handshake: one wait cycle, ack for one cycle.
  assign wbHit = wbCyc && wbReq.stb && !wbAck;
  assign wbWr = wbHit && wbReq.we && wbReq.sel[0];
  assign wbRd = wbHit && !wbReq.we;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wbAck <= 1'b0;
    end else if (clkEn) begin
      wbAck <= wbHit;
    end
  end

  // Configuration and address registers.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= tsb_pkg::CFG_RESET;
      hwgc_r <= tsb_pkg::REG_RESET;
      mstAdr_r <= tsb_pkg::REG_RESET;
      mask_r <= '0;
      for (int k = 0; k < 4; k++) begin
        id_r[k] <= '0;
      end
    end else if (clkEn) begin
      if (gcReset) begin
        cfg_r <= tsb_pkg::CFG_RESET;
      end else if (wbWr && wbReq.adr == tsb_pkg::CFG_OFS) begin
        cfg_r <= wbReq.dat[7:0];
        cfg_r[tsb_pkg::CFG_RSVD] <= 1'b0;
      end
      if (wbWr && wbReq.adr == tsb_pkg::HWGC_OFS) begin
        hwgc_r <= wbReq.dat[7:0];
      end
      if (wbWr && wbReq.adr == tsb_pkg::MADR_OFS) begin
        mstAdr_r <= wbReq.dat[7:0];
      end
      if (wbWr && wbReq.adr == tsb_pkg::MASK_OFS) begin
        mask_r <= wbReq.dat[tsb_pkg::ST_WIDTH-1:0];
      end
      if (wbWr && wbReq.adr == tsb_pkg::ID0_OFS) id_r[0] <= wbReq.dat[6:0];
      if (wbWr && wbReq.adr == tsb_pkg::ID1_OFS) id_r[1] <= wbReq.dat[6:0];
      if (wbWr && wbReq.adr == tsb_pkg::ID2_OFS) id_r[2] <= wbReq.dat[6:0];
      if (wbWr && wbReq.adr == tsb_pkg::ID3_OFS) id_r[3] <= wbReq.dat[6:0];
    end
  end

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    rdData = '0;
    unique case (wbReq.adr)
      tsb_pkg::CFG_OFS: rdData[7:0] = cfg_r;
      tsb_pkg::HWGC_OFS: rdData[7:0] = hwgc_r;
      tsb_pkg::MADR_OFS: rdData[7:0] = mstAdr_r;
      tsb_pkg::ID0_OFS: rdData[6:0] = id_r[0];
      tsb_pkg::ID1_OFS: rdData[6:0] = id_r[1];
      tsb_pkg::ID2_OFS: rdData[6:0] = id_r[2];
      tsb_pkg::ID3_OFS: rdData[6:0] = id_r[3];
      tsb_pkg::STAT_OFS: rdData[tsb_pkg::ST_WIDTH-1:0] = stat_r;
      tsb_pkg::MASK_OFS: rdData[tsb_pkg::ST_WIDTH-1:0] = mask_r;
      tsb_pkg::LIVE_OFS: rdData[3:0] = {mstBusy, sdaRx, sclRx, gcActive_r};
      default: rdData = '0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wbDatO <= '0;
    end else if (clkEn) begin
      wbDatO <= wbRd ? rdData : '0;
    end
  end

  // Sticky status: read clears, a new event in the same cycle wins.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= '0;
    end else if (clkEn) begin
      if (wbRd && wbReq.adr == tsb_pkg::STAT_OFS) begin
        stat_r <= evt;
      end else begin
        stat_r <= stat_r | evt;
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // Loopback feeds driven line levels into the receiver instead of the pins.
  assign sclRx = cfg_r[tsb_pkg::CFG_LOOP] ? !sclDrv : sclSync;
  assign sdaRx = cfg_r[tsb_pkg::CFG_LOOP] ? !sdaDrv : sdaSync;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclLast_r <= 1'b1;
    end else if (clkEn) begin
      sclLast_r <= sclRx;
    end
  end

  assign sclFall = sclLast_r && !sclRx;

  // Slave receiver with address match and general call decoding.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slv_r <= SL_IDLE;
      shift_r <= '0;
      bitCnt_r <= '0;
      gcActive_r <= 1'b0;
      sdaDrvLow_r <= 1'b0;
    end else if (clkEn) begin
      if (!cfg_r[tsb_pkg::CFG_SLV_EN] || lineEvent == tsb_pkg::EV_STOP) begin
        slv_r <= SL_IDLE;
        sdaDrvLow_r <= 1'b0;
        gcActive_r <= 1'b0;
      end else if (lineEvent == tsb_pkg::EV_START) begin
        slv_r <= SL_ADDR;
        bitCnt_r <= '0;
        sdaDrvLow_r <= 1'b0;
        gcActive_r <= 1'b0;
      end else begin
        unique case (slv_r)
          SL_IDLE, SL_SKIP: begin
          end
          SL_ADDR, SL_DATA: begin
            if (lineEvent == tsb_pkg::EV_BIT) begin
              shift_r <= {shift_r[6:0], sdaRx};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= '0;
              if (slv_r == SL_ADDR) begin
                if (shift_r == tsb_pkg::GC_ADDR && cfg_r[tsb_pkg::CFG_GC_EN]) begin
                  gcActive_r <= 1'b1;
                  sdaDrvLow_r <= 1'b1;
                  slv_r <= SL_AACK;
                end else if (idMatch(id_r, shift_r[7:1])) begin
                  sdaDrvLow_r <= 1'b1;
                  slv_r <= SL_AACK;
                end else begin
                  slv_r <= SL_SKIP;
                end
              end else begin
                sdaDrvLow_r <= 1'b1;
                slv_r <= SL_DACK;
              end
            end
          end
          SL_AACK, SL_DACK: begin
            if (sclFall) begin
              sdaDrvLow_r <= 1'b0;
              slv_r <= SL_DATA;
            end
          end
          default: slv_r <= SL_IDLE;
        endcase
      end
    end
  end

  // Events that set status bits, decoded at the address or data acknowledge or on lost arbitration.
  logic dataDone;
  assign dataDone = slv_r == SL_DATA && sclFall && bitCnt_r == 4'h8;
  assign gcReset = dataDone && gcActive_r && shift_r == tsb_pkg::GC_RESET_CMD;

  always_comb begin
    evt = '0;
    evt[tsb_pkg::ST_GC] = slv_r == SL_ADDR && sclFall && bitCnt_r == 4'h8
      && shift_r == tsb_pkg::GC_ADDR && cfg_r[tsb_pkg::CFG_GC_EN];
    evt[tsb_pkg::ST_HWGC] = dataDone && gcActive_r && cfg_r[tsb_pkg::CFG_HWGC_EN]
      && cfg_r[tsb_pkg::CFG_GC_EN] && shift_r == hwgc_r;
    evt[tsb_pkg::ST_GCRST] = gcReset;
    evt[tsb_pkg::ST_GCPROG] = dataDone && gcActive_r && shift_r == tsb_pkg::GC_PROG_CMD;
    evt[tsb_pkg::ST_ARBLOST] = mstArbLost;
    evt[tsb_pkg::ST_SLVMATCH] = slv_r == SL_ADDR && sclFall && bitCnt_r == 4'h8
      && idMatch(id_r, shift_r[7:1]);
  end

  // Master serial clock divider.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclDiv_r <= '0;
      sclGen_r <= 1'b1;
    end else if (clkEn) begin
      if (!cfg_r[tsb_pkg::CFG_SCL_EN] || mst_r != MS_RUN) begin
        sclDiv_r <= '0;
        sclGen_r <= 1'b1;
      end else if (sclDiv_r == 16'(tsb_pkg::SCL_HALF_CYC - 1)) begin
        sclDiv_r <= '0;
        sclGen_r <= !sclGen_r;
      end else begin
        sclDiv_r <= sclDiv_r + 16'h0001;
      end
    end
  end

  // Master address phase with arbitration check and start back-off.
  assign mstArbLost = mst_r == MS_RUN && sclRx && mstShift_r[7] && !sdaRx
    && sclDiv_r == '0;
  assign mstBusy = mst_r != MS_IDLE;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mst_r <= MS_IDLE;
      mstShift_r <= '0;
      mstBit_r <= '0;
      backoff_r <= '0;
    end else if (clkEn) begin
      if (!cfg_r[tsb_pkg::CFG_MST_EN]) begin
        mst_r <= MS_IDLE;
      end else begin
        unique case (mst_r)
          MS_IDLE: begin
            if (mstStart) begin
              mst_r <= MS_RUN;
              mstShift_r <= mstAdr_r;
              mstBit_r <= '0;
            end
          end
          MS_RUN: begin
            if (mstArbLost) begin
              if (cfg_r[tsb_pkg::CFG_NOBACKOFF]) begin
                mstShift_r <= mstAdr_r;
                mstBit_r <= '0;
              end else begin
                mst_r <= MS_WAIT;
                backoff_r <= 32'(BACKOFF_CYCLES);
              end
            end else if (sclFall && sclGen_r == 1'b0) begin
              mstShift_r <= {mstShift_r[6:0], 1'b1};
              mstBit_r <= mstBit_r + 4'h1;
              if (mstBit_r == 4'h8) begin
                mst_r <= MS_IDLE;
              end
            end
          end
          MS_WAIT: begin
            if (backoff_r == 32'h0000_0001) begin
              mst_r <= MS_RUN;
              mstShift_r <= mstAdr_r;
              mstBit_r <= '0;
            end
            backoff_r <= backoff_r - 32'h0000_0001;
          end
          default: mst_r <= MS_IDLE;
        endcase
      end
    end
  end

  // Open-drain drives: only low is driven; loopback keeps pins released.
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclDrv = !sclGen_r;
  assign sdaDrv = sdaDrvLow_r || (mst_r == MS_RUN && !mstShift_r[7]);
  assign sclOe = sclDrv && !cfg_r[tsb_pkg::CFG_LOOP];
  assign sdaOe = sdaDrv && !cfg_r[tsb_pkg::CFG_LOOP];
endmodule : tsb_config_ctrl

/* tsb_config_ctrl_sva.sv */
// Checker of the configuration control block at its ports.
module tsb_config_ctrl_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Register bus
  input wire logic wbCyc,
  input wire tsb_pkg::tsb_wbreq_type wbReq,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  // Lines, master and interrupt
  input wire tsb_pkg::tsb_pins_type pinsIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic mstStart,
  input wire logic mstBusy,
  input wire logic mstArbLost,
  input wire logic irq
);
  logic [7:0] cfgSh_r;
  logic wrCfg;
  assign wrCfg = wbCyc && wbReq.stb && wbReq.we && wbReq.sel[0] && clkEn && !wbAck
    && wbReq.adr == tsb_pkg::CFG_OFS;
  // The shadow follows software writes of the configuration byte.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfgSh_r <= 8'h00;
    end else if (wrCfg) begin
      cfgSh_r <= wbReq.dat[7:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_ack_follows: assert property (wbCyc && wbReq.stb && clkEn && !wbAck |=> wbAck)
    else $error("Request not acknowledged in the next cycle.");
  a_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("Acknowledge longer than one cycle.");
  a_ack_cause: assert property (wbAck |-> $past(wbCyc && wbReq.stb))
    else $error("Acknowledge without a request.");
  a_data_idle: assert property (!wbAck |-> wbDatO == 32'h0)
    else $error("Read data outside an acknowledge.");
  a_rsvd_zero: assert property (
    wbAck && !$past(wbReq.we) && $past(wbReq.adr) == tsb_pkg::CFG_OFS |-> !wbDatO[2])
    else $error("Reserved configuration bit read as one.");
  a_scl_stop: assert property ((!cfgSh_r[7]) [*2] |-> !sclOe)
    else $error("Serial clock driven while disabled.");
  a_master_off: assert property ((!cfgSh_r[1]) [*2] |-> !mstBusy && !mstArbLost)
    else $error("Master active while disabled.");
  a_loop_quiet: assert property (cfgSh_r[6] [*2] |-> !sclOe && !sdaOe)
    else $error("Lines driven in loopback.");
  a_slave_off: assert property ((cfgSh_r[3:0] == 4'h0) [*2] |-> !sdaOe)
    else $error("Data line driven with all channels off.");
  a_arb_pulse: assert property (mstArbLost |=> !mstArbLost)
    else $error("Lost arbitration pulse too long.");
  a_open_drain: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("Open-drain output level not low.");
  c_read: cover property (wbAck && !$past(wbReq.we));
  c_arb: cover property (mstArbLost);
  c_irq: cover property ($rose(irq));
  c_slave_ack: cover property (sdaOe && !mstBusy);
endmodule : tsb_config_ctrl_sva

bind tsb_config_ctrl tsb_config_ctrl_sva u_sva (.clock(clock), .rst_b(rst_b), .clkEn(clkEn),
  .wbCyc(wbCyc), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .pinsIn(pinsIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .mstStart(mstStart),
  .mstBusy(mstBusy), .mstArbLost(mstArbLost), .irq(irq));

/* tsb_bus_partner.sv */
// Model of another party on the shared two-wire bus with pull-up lines.
module tsb_bus_partner (
  // Lines pulled by the block
  input wire logic sclOe,
  input wire logic sdaOe,
  // Resolved line levels
  output tsb_pkg::tsb_pins_type pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclPull = 1'b0;
  logic sdaPull = 1'b0;
  // Released lines float high through their pull-ups.
  assign pins = '{sclIn: !(sclOe || sclPull), sdaIn: !(sdaOe || sdaPull)};
  task automatic stop;
    sdaPull = 1'b1;
    #80;
    sdaPull = 1'b0;
    #80;
  endtask : stop
  task automatic xbyte(input logic [7:0] b, output logic k);
    for (int i = 7; i >= 0; i--) begin
      sdaPull = !b[i];
      #40;
      sclPull = 1'b0;
      #80;
      sclPull = 1'b1;
      #40;
    end
    sdaPull = 1'b0;
    #40;
    sclPull = 1'b0;
    #40;
    k = sdaOe;
    #40;
    sclPull = 1'b1;
    #40;
  endtask : xbyte
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [1:0] k);
    sdaPull = 1'b1;
    #80;
    sclPull = 1'b1;
    #40;
    xbyte(a, k[1]);
    xbyte(d, k[0]);
    sdaPull = 1'b1;
    #40;
    sclPull = 1'b0;
    #40;
    stop();
  endtask : frame
endmodule : tsb_bus_partner

/* tsb_config_ctrl_tb.sv */
// Self-checking bench of the configuration control block.
module tsb_config_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BO = 2000;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic wbCyc = 1'b0;
  tsb_pkg::tsb_wbreq_type wbReq = '0;
  logic [31:0] wbDatO;
  logic wbAck;
  tsb_pkg::tsb_pins_type pins;
  logic sclOe;
  logic sdaOe;
  logic mstStart = 1'b0;
  logic mstBusy;
  logic mstArbLost;
  logic irq;
  int numErrors = 0;
  int totalChecks = 0;
  logic [31:0] q;
  logic [1:0] k;
  tsb_config_ctrl #(.BACKOFF_CYCLES(BO)) uut (.clock(clock), .rst_b(rst_b), .clkEn(clkEn),
    .wbCyc(wbCyc), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .pinsIn(pins),
    .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe), .mstStart(mstStart),
    .mstBusy(mstBusy), .mstArbLost(mstArbLost), .irq(irq));
  tsb_bus_partner plm (.sclOe(sclOe), .sdaOe(sdaOe), .pins(pins));
  always #2 clock = ~clock;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w,
      input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbReq <= '{adr: a, dat: d, sel: s, we: w, stb: 1'b1};
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbReq.stb <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(a, 32'h0, 1'b0, 4'hF, r);
    chk(r, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, d, 1'b1, 4'hF, r);
  endtask : wr
  task automatic tRegs;
    logic [7:0] ofs [6];
    int n;
    ofs = '{tsb_pkg::CFG_OFS, tsb_pkg::HWGC_OFS, tsb_pkg::ID0_OFS, tsb_pkg::ID1_OFS,
      tsb_pkg::ID2_OFS, tsb_pkg::ID3_OFS};
    foreach (ofs[i]) begin
      rd(ofs[i], 32'h0);
    end
    wb(tsb_pkg::CFG_OFS, 32'hFF, 1'b1, 4'hE, q);
    rd(tsb_pkg::CFG_OFS, 32'h0);
    wr(tsb_pkg::CFG_OFS, 32'hFF);
    rd(tsb_pkg::CFG_OFS, 32'hFB);
    wr(8'hF0, 32'hFF);
    rd(8'hF0, 32'h0);
    wr(tsb_pkg::CFG_OFS, 32'h0);
    @(posedge clock);
    clkEn <= 1'b0;
    wbCyc <= 1'b1;
    wbReq <= '{adr: tsb_pkg::HWGC_OFS, dat: 32'h33, sel: 4'hF, we: 1'b1, stb: 1'b1};
    repeat (4) @(posedge clock);
    chk(wbAck, 32'h0);
    clkEn <= 1'b1;
    n = 0;
    while (wbAck !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    wbCyc <= 1'b0;
    wbReq.stb <= 1'b0;
    chk(32'(n < 50), 32'h1);
    rd(tsb_pkg::HWGC_OFS, 32'h33);
    $display("Test registers done");
  endtask : tRegs
  task automatic tSlave;
    logic [6:0] ids [4];
    ids = '{7'h12, 7'h2D, 7'h40, 7'h7F};
    wr(tsb_pkg::CFG_OFS, 32'h01);
    foreach (ids[i]) begin
      wr(tsb_pkg::ID0_OFS + 8'(4 * i), 32'(ids[i]));
    end
    foreach (ids[i]) begin
      plm.frame({ids[i], 1'b0}, 8'hA5, k);
      chk(k[1], 32'h1);
      chk(irq, 32'h0);
      rd(tsb_pkg::STAT_OFS, 32'h20);
    end
    plm.frame(8'h44, 8'hA5, k);
    chk(k, 32'h0);
    wr(tsb_pkg::CFG_OFS, 32'h0);
    plm.frame({ids[0], 1'b0}, 8'hA5, k);
    chk(k, 32'h0);
    $display("Test slave done");
  endtask : tSlave
  task automatic tGc;
    wr(tsb_pkg::MASK_OFS, 32'h0F);
    wr(tsb_pkg::CFG_OFS, 32'h09);
    plm.frame(8'h00, 8'h04, k);
    chk(k, 32'h3);
    chk(irq, 32'h1);
    rd(tsb_pkg::STAT_OFS, 32'h09);
    rd(tsb_pkg::STAT_OFS, 32'h00);
    chk(irq, 32'h0);
    wr(tsb_pkg::ID0_OFS, 32'h15);
    wr(tsb_pkg::HWGC_OFS, 32'h5B);
    wr(tsb_pkg::CFG_OFS, 32'h19);
    plm.frame(8'h00, 8'h5B, k);
    rd(tsb_pkg::STAT_OFS, 32'h03);
    plm.frame(8'h00, 8'h06, k);
    rd(tsb_pkg::STAT_OFS, 32'h05);
    rd(tsb_pkg::CFG_OFS, 32'h00);
    plm.frame(8'h00, 8'h06, k);
    chk(k, 32'h0);
    rd(tsb_pkg::STAT_OFS, 32'h00);
    wr(tsb_pkg::CFG_OFS, 32'h09);
    rd(tsb_pkg::CFG_OFS, 32'h09);
    wr(tsb_pkg::CFG_OFS, 32'h00);
    $display("Test general call done");
  endtask : tGc
  task automatic tMaster;
    int n;
    wr(tsb_pkg::MADR_OFS, 32'hA0);
    wr(tsb_pkg::CFG_OFS, 32'h80);
    mstStart <= 1'b1;
    repeat (40) @(posedge clock);
    chk(mstBusy, 32'h0);
    wr(tsb_pkg::CFG_OFS, 32'h02);
    repeat (400) @(posedge clock);
    chk(mstBusy, 32'h1);
    chk(sclOe, 32'h0);
    wr(tsb_pkg::CFG_OFS, 32'h80);
    for (int p = 1; p >= 0; p--) begin
      wr(tsb_pkg::CFG_OFS, 32'h82 | 32'(p << 5));
      n = 0;
      while (sdaOe !== 1'b1 && n < 5000) begin
        @(posedge clock);
        n++;
      end
      chk(mstBusy, 32'h1);
      plm.sdaPull <= 1'b1;
      n = 0;
      while (mstArbLost !== 1'b1 && n < 5000) begin
        @(posedge clock);
        n++;
      end
      chk(32'(n < 5000), 32'h1);
      plm.sdaPull <= 1'b0;
      n = 0;
      while (sdaOe !== 1'b1 && n < 3 * BO) begin
        @(posedge clock);
        n++;
      end
      chk(32'(n < BO), 32'(p));
      wr(tsb_pkg::CFG_OFS, 32'h80);
      plm.stop();
    end
    wr(tsb_pkg::CFG_OFS, 32'hC2);
    n = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && n < 400) begin
      wb(tsb_pkg::LIVE_OFS, 32'h0, 1'b0, 4'hF, q);
      n++;
    end
    chk(32'(n < 400), 32'h1);
    chk(pins.sclIn, 32'h1);
    wr(tsb_pkg::CFG_OFS, 32'h0);
    mstStart <= 1'b0;
    $display("Test master done");
  endtask : tMaster
  task automatic printVerdict;
    $display("Checks %0d, errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : printVerdict
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    tRegs();
    tSlave();
    tGc();
    tMaster();
    printVerdict();
  end
  initial begin
    #200000;
    numErrors++;
    printVerdict();
  end
endmodule : tsb_config_ctrl_tb
